// ---- design/cdcb_defs.svh ----
// offsets, field positions, reset values and timing constants of the clock config bank
`ifndef CDCB_DEFS_SVH
`define CDCB_DEFS_SVH
// ----------------------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------------------
`define CDCB_IDX_LEVEL 4'h9
`define CDCB_IDX_LOCK 4'hb
`define CDCB_IDX_FILTER 4'hd
`define CDCB_IDX_REFGLB 4'he
`define CDCB_IDX_FBDIV 4'hf
`define CDCB_IDX_STATUS 5'h10
// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CDCB_SOFT_RESET_BIT 31
`define CDCB_CH_ENABLE_BIT 16
`define CDCB_BOOST_BIT 16
`define CDCB_PRESCALE_BIT 15
`define CDCB_AUX_EN_BIT 28
`define CDCB_GLOBAL_EN_BIT 27
`define CDCB_SLEEP_BIT 26
// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define CDCB_RST_PATH 2'h0
`define CDCB_RST_DIV 8'h01
`define CDCB_RST_DLY 4'h0
`define CDCB_RST_REF_FREQ 8'h0a
`define CDCB_RST_REF_DIV 12'h00a
`define CDCB_RST_OSC_DIV 4'h2
`define CDCB_RST_FB_DIV 18'h002f8
`define CDCB_DLY_STEP_PS 150
// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CDCB_CLK_PERIOD_NS 4
`define CDCB_CAL_TIME_NS 400
`define CDCB_CAL_CYCLES (`CDCB_CAL_TIME_NS / `CDCB_CLK_PERIOD_NS)
`endif

// ---- design/cdcb_pkg.sv ----
// types shared by the clock config bank
package cdcb_pkg;
  // per-output channel settings
  typedef struct packed {
    logic [1:0] output_path_select;
    logic output_channel_enable;
    logic [7:0] output_divider_code;
    logic [3:0] output_delay_code;
  } cdcb_chan_type;
  // path select encodings
  typedef enum logic [1:0] {
    CDCB_BYPASS = 2'h0,
    CDCB_DIVIDED = 2'h1,
    CDCB_DELAYED = 2'h2,
    CDCB_DIV_DLY = 2'h3
  } cdcb_path_type;
  // effective per-output drive to the analog channel
  typedef struct packed {
    logic driven;
    logic use_divider;
    logic use_delay;
    logic [8:0] divide_ratio;
    logic [11:0] delay_ps;
  } cdcb_drive_type;
endpackage : cdcb_pkg

// ---- design/cdcb_bank.sv ----
// apb register bank configuring the clock distribution outputs
// ----------------------------------------------------------------------------
// Notes on behaviour
// - reset bit in channel zero restores defaults
// - reset write ignores other channel zero fields
// - path select picks bypass, divide, delay, both
// - divider used only in divided modes
// - divide ratio is twice the code
// - total ratio is oscillator times output ratio
// - delay used only in delayed modes
// - delay is code times 150 ps
// - output needs own, global bit and pin
// - channels start disabled, bypass, divide two
// - boost bit defaults to normal level
// - reference frequency field resets to ten
// - filter selects hold three fields, reset zero
// - aux enable, global enable, sleep bits
// - lock pin select and reference divider
// - prescale divides lock detect input by four
// - sleep gates channel drives, boost, aux enable and lock tick; calibration timer keeps running
// - feedback register write starts calibration
// ----------------------------------------------------------------------------
`include "cdcb_defs.svh"

module cdcb_bank (
  input wire logic CLOCK_IN, // 250 mhz clock
  input wire logic RESET_N_IN, // async reset, active low
  input wire logic PSEL_IN, // apb select
  input wire logic PENABLE_IN, // apb access phase
  input wire logic PWRITE_IN, // apb direction
  input wire logic [6:0] PADDR_IN, // apb byte address
  input wire logic [31:0] PWDATA_IN, // apb write data
  input wire logic GLOBAL_OUTPUT_ENABLE_PIN_IN, // output enable pin, high or open
  input wire logic LOCK_DETECT_CLK_IN, // phase detector rate enable pulse
  output logic [31:0] PRDATA_OUT, // apb read data
  output logic PREADY_OUT, // apb ready
  output logic PSLVERR_OUT, // apb error on unmapped address
  output cdcb_pkg::cdcb_drive_type [7:0] CHANNEL_DRIVE_OUT, // per output drive
  output logic [4:0] TOTAL_RATIO_SCALE_OUT, // oscillator divider for total ratio
  output logic OUTPUT_BOOST_OUT, // boosted output level
  output logic LOCK_DETECT_TICK_OUT, // pulse feeding digital lock detect
  output logic AUX_OUTPUT_ENABLE_OUT, // aux oscillator output enable
  output logic DEVICE_SLEEP_OUT, // device sleep; drives, boost, aux enable and lock tick gated
  output logic [3:0] LOCK_PIN_SELECT_OUT, // lock status pin function
  output logic [11:0] REFERENCE_DIVIDER_OUT, // reference divider value
  output logic [7:0] REFERENCE_FREQ_MHZ_OUT, // reference frequency in mhz
  output logic [9:0] LOOP_FILTER_OUT, // r4, r3, capacitor selects
  output logic [1:0] CHARGE_PUMP_GAIN_OUT, // charge pump gain
  output logic [17:0] FEEDBACK_DIVIDER_OUT, // feedback divider value
  output logic CALIBRATION_BUSY_OUT // frequency calibration running
);
  import cdcb_pkg::*;

  // ----------------------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------------------
  cdcb_chan_type chan [8];
  logic output_boost;
  logic lock_detect_prescale;
  logic [7:0] reference_freq_mhz;
  logic [2:0] filter_resistor_four_sel;
  logic [2:0] filter_resistor_three_sel;
  logic [3:0] filter_capacitor_sel;
  logic aux_output_enable;
  logic global_output_enable;
  logic device_sleep;
  logic [3:0] lock_pin_select;
  logic [11:0] reference_divider;
  logic [1:0] charge_pump_gain;
  logic [3:0] oscillator_divider;
  logic [17:0] feedback_divider;
  logic [8:0] cal_count;
  logic [1:0] prescale_count;

  // ----------------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------------
  logic [4:0] reg_index;
  logic addr_valid;
  logic access;
  logic wr_en;
  logic soft_reset;
  logic [31:0] rd_mux;
  logic [31:0] w;

  assign reg_index = PADDR_IN[6:2];
  assign w = PWDATA_IN;
  // mapped: channels, level, lock, filter, refglb, fbdiv, status, word aligned
  always_comb
  begin
    addr_valid = (PADDR_IN[1:0] == 2'h0) &&
                 ((reg_index < 5'h08) ||
                  (reg_index == {1'b0, `CDCB_IDX_LEVEL}) ||
                  (reg_index == {1'b0, `CDCB_IDX_LOCK}) ||
                  (reg_index == {1'b0, `CDCB_IDX_FILTER}) ||
                  (reg_index == {1'b0, `CDCB_IDX_REFGLB}) ||
                  (reg_index == {1'b0, `CDCB_IDX_FBDIV}) ||
                  (reg_index == `CDCB_IDX_STATUS));
  end

  // zero wait state slave
  assign access = PSEL_IN && PENABLE_IN;
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = access && !addr_valid;
  assign wr_en = access && PWRITE_IN && addr_valid;
  // reset bit set in a channel zero write overrides everything else
  assign soft_reset = wr_en && (reg_index == 5'h00) && w[`CDCB_SOFT_RESET_BIT];

  // ----------------------------------------------------------------------------
  // channel registers, one per output
  // ----------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : gen_chan
      // fields hold until rewritten or reset; reset write loads defaults only
      always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
      begin
        if (!RESET_N_IN)
        begin
          chan[g] <= '{`CDCB_RST_PATH, 1'b0, `CDCB_RST_DIV, `CDCB_RST_DLY};
        end
        else if (soft_reset)
        begin
          chan[g] <= '{`CDCB_RST_PATH, 1'b0, `CDCB_RST_DIV, `CDCB_RST_DLY};
        end
        else if (wr_en && (reg_index == 5'(g)))
        begin
          chan[g] <= '{w[18:17], w[`CDCB_CH_ENABLE_BIT], w[15:8], w[7:4]};
        end
      end

      // effective path per output
      always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
      begin
        if (!RESET_N_IN)
        begin
          CHANNEL_DRIVE_OUT[g] <= '0;
        end
        else
        begin
          CHANNEL_DRIVE_OUT[g].driven <= chan[g].output_channel_enable &&
            global_output_enable && GLOBAL_OUTPUT_ENABLE_PIN_IN && !device_sleep;
          CHANNEL_DRIVE_OUT[g].use_divider <= chan[g].output_path_select[0];
          CHANNEL_DRIVE_OUT[g].use_delay <= chan[g].output_path_select[1];
          CHANNEL_DRIVE_OUT[g].divide_ratio <= chan[g].output_path_select[0] ?
            {chan[g].output_divider_code, 1'b0} : 9'h001;
          CHANNEL_DRIVE_OUT[g].delay_ps <= chan[g].output_path_select[1] ?
            12'(chan[g].output_delay_code * `CDCB_DLY_STEP_PS) : 12'h000;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // global registers
  // ----------------------------------------------------------------------------
  // level, lock detect prescale and loop filter
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      output_boost <= 1'b0;
      lock_detect_prescale <= 1'b0;
      reference_freq_mhz <= `CDCB_RST_REF_FREQ;
      filter_resistor_four_sel <= 3'h0;
      filter_resistor_three_sel <= 3'h0;
      filter_capacitor_sel <= 4'h0;
    end
    else if (soft_reset)
    begin
      output_boost <= 1'b0;
      lock_detect_prescale <= 1'b0;
      reference_freq_mhz <= `CDCB_RST_REF_FREQ;
      filter_resistor_four_sel <= 3'h0;
      filter_resistor_three_sel <= 3'h0;
      filter_capacitor_sel <= 4'h0;
    end
    else if (wr_en)
    begin
      if (reg_index == {1'b0, `CDCB_IDX_LEVEL})
      begin
        output_boost <= w[`CDCB_BOOST_BIT];
      end
      if (reg_index == {1'b0, `CDCB_IDX_LOCK})
      begin
        lock_detect_prescale <= w[`CDCB_PRESCALE_BIT];
      end
      if (reg_index == {1'b0, `CDCB_IDX_FILTER})
      begin
        reference_freq_mhz <= w[21:14];
        filter_resistor_four_sel <= w[13:11];
        filter_resistor_three_sel <= w[10:8];
        filter_capacitor_sel <= w[7:4];
      end
    end
  end

  // reference and global control
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      aux_output_enable <= 1'b0;
      global_output_enable <= 1'b1;
      device_sleep <= 1'b0;
      lock_pin_select <= 4'h0;
      reference_divider <= `CDCB_RST_REF_DIV;
    end
    else if (soft_reset)
    begin
      aux_output_enable <= 1'b0;
      global_output_enable <= 1'b1;
      device_sleep <= 1'b0;
      lock_pin_select <= 4'h0;
      reference_divider <= `CDCB_RST_REF_DIV;
    end
    else if (wr_en && (reg_index == {1'b0, `CDCB_IDX_REFGLB}))
    begin
      aux_output_enable <= w[`CDCB_AUX_EN_BIT];
      global_output_enable <= w[`CDCB_GLOBAL_EN_BIT];
      device_sleep <= w[`CDCB_SLEEP_BIT];
      lock_pin_select <= w[23:20];
      reference_divider <= w[19:8];
    end
  end

  // feedback and oscillator dividers
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      charge_pump_gain <= 2'h0;
      oscillator_divider <= `CDCB_RST_OSC_DIV;
      feedback_divider <= `CDCB_RST_FB_DIV;
    end
    else if (soft_reset)
    begin
      charge_pump_gain <= 2'h0;
      oscillator_divider <= `CDCB_RST_OSC_DIV;
      feedback_divider <= `CDCB_RST_FB_DIV;
    end
    else if (wr_en && (reg_index == {1'b0, `CDCB_IDX_FBDIV}))
    begin
      charge_pump_gain <= w[31:30];
      oscillator_divider <= w[29:26];
      feedback_divider <= w[25:8];
    end
  end

  // ----------------------------------------------------------------------------
  // calibration timer and lock detect prescaler
  // ----------------------------------------------------------------------------
  // every feedback write restarts the calibration window
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      cal_count <= 9'h000;
    end
    else if (wr_en && (reg_index == {1'b0, `CDCB_IDX_FBDIV}) && !soft_reset)
    begin
      cal_count <= 9'(`CDCB_CAL_CYCLES);
    end
    else if (soft_reset)
    begin
      cal_count <= 9'h000;
    end
    else if (cal_count != 9'h000)
    begin
      cal_count <= cal_count - 9'h001;
    end
  end

  // divide lock detect ticks by four when prescale is set
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      prescale_count <= 2'h0;
      LOCK_DETECT_TICK_OUT <= 1'b0;
    end
    else
    begin
      if (LOCK_DETECT_CLK_IN)
      begin
        prescale_count <= prescale_count + 2'h1;
      end
      LOCK_DETECT_TICK_OUT <= LOCK_DETECT_CLK_IN && !device_sleep &&
        (!lock_detect_prescale || (prescale_count == 2'h3));
    end
  end

  // ----------------------------------------------------------------------------
  // outputs and read back
  // ----------------------------------------------------------------------------
  assign TOTAL_RATIO_SCALE_OUT = {1'b0, oscillator_divider};
  assign OUTPUT_BOOST_OUT = output_boost && !device_sleep;
  assign AUX_OUTPUT_ENABLE_OUT = aux_output_enable && !device_sleep;
  assign DEVICE_SLEEP_OUT = device_sleep;
  assign LOCK_PIN_SELECT_OUT = lock_pin_select;
  assign REFERENCE_DIVIDER_OUT = reference_divider;
  assign REFERENCE_FREQ_MHZ_OUT = reference_freq_mhz;
  assign LOOP_FILTER_OUT = {filter_resistor_four_sel, filter_resistor_three_sel,
                            filter_capacitor_sel};
  assign CHARGE_PUMP_GAIN_OUT = charge_pump_gain;
  assign FEEDBACK_DIVIDER_OUT = feedback_divider;
  assign CALIBRATION_BUSY_OUT = (cal_count != 9'h000);

  // read mux; reset bit always reads zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (reg_index < 5'h08)
    begin
      rd_mux[18:17] = chan[reg_index[2:0]].output_path_select;
      rd_mux[16] = chan[reg_index[2:0]].output_channel_enable;
      rd_mux[15:8] = chan[reg_index[2:0]].output_divider_code;
      rd_mux[7:4] = chan[reg_index[2:0]].output_delay_code;
    end
    else if (reg_index == {1'b0, `CDCB_IDX_LEVEL})
    begin
      rd_mux[`CDCB_BOOST_BIT] = output_boost;
    end
    else if (reg_index == {1'b0, `CDCB_IDX_LOCK})
    begin
      rd_mux[`CDCB_PRESCALE_BIT] = lock_detect_prescale;
    end
    else if (reg_index == {1'b0, `CDCB_IDX_FILTER})
    begin
      rd_mux[21:4] = {reference_freq_mhz, filter_resistor_four_sel,
                      filter_resistor_three_sel, filter_capacitor_sel};
    end
    else if (reg_index == {1'b0, `CDCB_IDX_REFGLB})
    begin
      rd_mux[28:26] = {aux_output_enable, global_output_enable, device_sleep};
      rd_mux[23:8] = {lock_pin_select, reference_divider};
    end
    else if (reg_index == {1'b0, `CDCB_IDX_FBDIV})
    begin
      rd_mux[31:8] = {charge_pump_gain, oscillator_divider, feedback_divider};
    end
    else if (reg_index == `CDCB_IDX_STATUS)
    begin
      rd_mux[0] = CALIBRATION_BUSY_OUT;
    end
  end

  // read data registered for the access phase
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      PRDATA_OUT <= 32'h0000_0000;
    end
    else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN && addr_valid)
    begin
      PRDATA_OUT <= rd_mux;
    end
  end
endmodule : cdcb_bank

// ---- verif/cdcb_bank_properties.sv ----
// concurrent checks on the ports of the clock config bank
module cdcb_bank_properties (
  input wire logic CLOCK_IN, // clock
  input wire logic RESET_N_IN, // reset, active low
  input wire logic PSEL_IN, // select
  input wire logic PENABLE_IN, // access phase
  input wire logic PWRITE_IN, // direction
  input wire logic [6:0] PADDR_IN, // byte address
  input wire logic [31:0] PWDATA_IN, // write data
  input wire logic GLOBAL_OUTPUT_ENABLE_PIN_IN, // enable pin
  input wire logic LOCK_DETECT_CLK_IN, // lock rate pulse
  input wire cdcb_pkg::cdcb_drive_type [7:0] CHANNEL_DRIVE_OUT, // per output drive
  input wire logic LOCK_DETECT_TICK_OUT, // lock tick
  input wire logic DEVICE_SLEEP_OUT, // sleep
  input wire logic [11:0] REFERENCE_DIVIDER_OUT, // reference divider
  input wire logic [7:0] REFERENCE_FREQ_MHZ_OUT, // reference frequency
  input wire logic [17:0] FEEDBACK_DIVIDER_OUT, // feedback divider
  input wire logic CALIBRATION_BUSY_OUT // calibration running
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------------------
  // access decode
  // --------------------------------------------------------------------------
  logic acc;
  logic wr0;
  logic [7:0] drv;
  assign acc = PSEL_IN & PENABLE_IN;
  assign wr0 = acc & PWRITE_IN & (PADDR_IN == 7'h00) & PWDATA_IN[31];
  // driven flag of every output
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      drv[i] = CHANNEL_DRIVE_OUT[i].driven;
  end
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (!RESET_N_IN);
  // --------------------------------------------------------------------------
  // properties
  // --------------------------------------------------------------------------
  chk_soft_reset_defaults: assert property (wr0 |=> REFERENCE_DIVIDER_OUT == 12'h00a
    && REFERENCE_FREQ_MHZ_OUT == 8'h0a && FEEDBACK_DIVIDER_OUT == 18'h002f8)
    else $error("soft reset left a field off its default");
  chk_reset_drops_fields: assert property (wr0 |-> ##2 drv == 8'h00)
    else $error("soft reset write kept an output enabled");
  chk_cal_start: assert property (acc && PWRITE_IN && PADDR_IN == 7'h3c |=> CALIBRATION_BUSY_OUT [*8])
    else $error("feedback write did not start calibration");
  chk_value_holds: assert property (!(acc && PWRITE_IN) |=>
    $stable(FEEDBACK_DIVIDER_OUT) && $stable(REFERENCE_DIVIDER_OUT))
    else $error("divider changed without a write");
  chk_sleep_gate: assert property (DEVICE_SLEEP_OUT |=> drv == 8'h00)
    else $error("output driven while asleep");
  chk_pin_gate: assert property (!GLOBAL_OUTPUT_ENABLE_PIN_IN |=> drv == 8'h00)
    else $error("output driven with enable pin low");
  chk_tick_cause: assert property (LOCK_DETECT_TICK_OUT |-> $past(LOCK_DETECT_CLK_IN))
    else $error("lock tick without input pulse");
  chk_bypass_ratio: assert property (CHANNEL_DRIVE_OUT[1].driven
    && !CHANNEL_DRIVE_OUT[1].use_divider |-> CHANNEL_DRIVE_OUT[1].divide_ratio == 9'h001)
    else $error("divider applied outside divided modes");
  chk_bypass_delay: assert property (CHANNEL_DRIVE_OUT[1].driven
    && !CHANNEL_DRIVE_OUT[1].use_delay |-> CHANNEL_DRIVE_OUT[1].delay_ps == 12'h000)
    else $error("delay applied outside delayed modes");
  chk_even_ratio: assert property (CHANNEL_DRIVE_OUT[2].use_divider
    |-> CHANNEL_DRIVE_OUT[2].divide_ratio[0] == 1'b0)
    else $error("odd output divide ratio");
endmodule : cdcb_bank_properties

bind cdcb_bank cdcb_bank_properties u_props (.CLOCK_IN, .RESET_N_IN, .PSEL_IN, .PENABLE_IN,
  .PWRITE_IN, .PADDR_IN, .PWDATA_IN, .GLOBAL_OUTPUT_ENABLE_PIN_IN, .LOCK_DETECT_CLK_IN,
  .CHANNEL_DRIVE_OUT, .LOCK_DETECT_TICK_OUT, .DEVICE_SLEEP_OUT, .REFERENCE_DIVIDER_OUT,
  .REFERENCE_FREQ_MHZ_OUT, .FEEDBACK_DIVIDER_OUT, .CALIBRATION_BUSY_OUT);

// ---- verif/cdcb_host.sv ----
// host controller model: apb master issuing register transfers
module cdcb_host (
  input wire logic clk_in, // bus clock
  input wire logic pready_in, // slave ready
  input wire logic pslverr_in, // slave error
  input wire logic [31:0] prdata_in, // read data
  output logic psel_out = 1'b0, // select
  output logic penable_out = 1'b0, // access phase
  output logic pwrite_out = 1'b0, // direction
  output logic [6:0] paddr_out = 7'h00, // byte address
  output logic [31:0] pwdata_out = 32'h00000000, // write data
  output logic hang_out = 1'b0 // transfer never answered
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------------------
  // one transfer: setup, then access held until ready
  // --------------------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [4:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk_in);
    psel_out <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out <= wr;
    paddr_out <= {idx, 2'b00};
    pwdata_out <= wd;
    @(posedge clk_in);
    penable_out <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (pready_in !== 1'b1 && n < 20);
    hang_out <= (pready_in !== 1'b1);
    rd = prdata_in;
    err = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
  endtask : xfer
endmodule : cdcb_host

// ---- verif/cdcb_bank_bench.sv ----
// self-checking bench for the clock config bank
module cdcb_bank_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cdcb_pkg::*;
  // --------------------------------------------------------------------------
  // signals
  // --------------------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pin = 1'b1;
  logic lck = 1'b0;
  logic psel, pen, pwr, pready, pslverr, hang, boost, tick, sleep, busy, e;
  logic [6:0] paddr;
  logic [31:0] pwdata, prdata, d;
  cdcb_drive_type [7:0] drive;
  cdcb_drive_type x;
  logic [4:0] scale;
  logic aux;
  logic [3:0] lpsel;
  logic [9:0] lf;
  logic [11:0] rdiv;
  logic [7:0] rfreq;
  logic [1:0] gain;
  logic [17:0] fbd;
  int n_errors = 0;
  int cmp_count = 0;
  int ticks = 0;
  int n;
  logic [4:0] ri [7] = '{5'h09, 5'h0b, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h08};
  logic [31:0] rv [7] = '{32'h0, 32'h0, 32'h00028000, 32'h08000a00, 32'h0802f800, 32'h0, 32'h0};
  cdcb_bank DUT (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .GLOBAL_OUTPUT_ENABLE_PIN_IN(pin),
    .LOCK_DETECT_CLK_IN(lck), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .CHANNEL_DRIVE_OUT(drive), .TOTAL_RATIO_SCALE_OUT(scale), .OUTPUT_BOOST_OUT(boost),
    .LOCK_DETECT_TICK_OUT(tick), .AUX_OUTPUT_ENABLE_OUT(aux), .DEVICE_SLEEP_OUT(sleep),
    .LOCK_PIN_SELECT_OUT(lpsel), .REFERENCE_DIVIDER_OUT(rdiv), .REFERENCE_FREQ_MHZ_OUT(rfreq),
    .LOOP_FILTER_OUT(lf), .CHARGE_PUMP_GAIN_OUT(gain), .FEEDBACK_DIVIDER_OUT(fbd),
    .CALIBRATION_BUSY_OUT(busy));
  cdcb_host host (.clk_in(clk), .pready_in(pready), .pslverr_in(pslverr), .prdata_in(prdata),
    .psel_out(psel), .penable_out(pen), .pwrite_out(pwr), .paddr_out(paddr),
    .pwdata_out(pwdata), .hang_out(hang));
  // --------------------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // write, then let the registered drive outputs follow
  task automatic wr(input logic [4:0] i, input logic [31:0] v);
    host.xfer(1'b1, i, v, d, e);
    @(posedge clk);
    #1;
  endtask : wr
  task automatic rd(input logic [4:0] i, input logic [31:0] v, input logic ee);
    host.xfer(1'b0, i, 32'h0, d, e);
    check(d, v);
    check({31'h0, e}, {31'h0, ee});
  endtask : rd
  task automatic pulses(input int k, input int exp);
    int t0;
    t0 = ticks;
    repeat (k)
    begin
      @(posedge clk);
      lck <= 1'b1;
      @(posedge clk);
      lck <= 1'b0;
    end
    repeat (3) @(posedge clk);
    check(ticks - t0, exp);
  endtask : pulses
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  // --------------------------------------------------------------------------
  // clock, tick count, hang watch
  // --------------------------------------------------------------------------
  initial
  begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (tick === 1'b1)
      ticks++;
  end
  always @(posedge hang)
  begin
    n_errors++;
    complete_run();
  end
  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    // power-on values, outputs off
    for (int i = 0; i < 8; i++)
    begin
      rd(5'(i), 32'h00000100, 1'b0);
      check({31'h0, drive[i].driven}, 32'h0);
    end
    for (int i = 0; i < 7; i++)
      rd(ri[i], rv[i], ri[i] == 5'h08);
    // every path mode with top codes on outputs 1 to 4
    for (int p = 0; p < 4; p++)
    begin
      wr(5'(p + 1), {13'h0, 2'(p), 1'b1, 8'hff, 4'hf, 4'h0});
      x.driven = 1'b1;
      x.use_divider = p[0];
      x.use_delay = p[1];
      x.divide_ratio = p[0] ? 9'h1fe : 9'h001;
      x.delay_ps = p[1] ? 12'h8ca : 12'h000;
      check({8'h0, drive[p + 1]}, {8'h0, x});
    end
    // pin low, then global bit low
    @(posedge clk);
    pin <= 1'b0;
    repeat (2) @(posedge clk);
    check({31'h0, drive[1].driven}, 32'h0);
    pin <= 1'b1;
    wr(5'h0e, 32'h00000a00);
    check({31'h0, drive[2].driven}, 32'h0);
    // boost, then sleep gates it, contents kept
    wr(5'h09, 32'h00010000);
    check({31'h0, boost}, 32'h1);
    wr(5'h0e, 32'h0c700a00);
    check({30'h0, sleep, boost}, 32'h2);
    rd(5'h0e, 32'h0c700a00, 1'b0);
    check({28'h0, lpsel}, 32'h7);
    wr(5'h0e, 32'h18000a00);
    check({31'h0, aux}, 32'h1);
    check({31'h0, drive[1].driven}, 32'h1);
    // lock tick with and without prescale
    pulses(8, 8);
    wr(5'h0b, 32'h00008000);
    pulses(8, 2);
    // feedback write starts calibration
    wr(5'h0f, 32'h54012300);
    check({12'h0, gain, fbd}, {12'h0, 2'h1, 18'h00123});
    check({27'h0, scale}, 32'h5);
    rd(5'h10, 32'h1, 1'b0);
    n = 0;
    while (busy !== 1'b0 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    check({31'h0, busy}, 32'h0);
    // loop filter and reference frequency away from defaults
    wr(5'h0d, 32'h003223b0);
    check({24'h0, rfreq}, 32'hc8);
    check({22'h0, lf}, 32'h23b);
    rd(5'h0d, 32'h003223b0, 1'b0);
    // soft reset with every other bit set
    wr(5'h00, 32'hffffffff);
    rd(5'h00, 32'h00000100, 1'b0);
    rd(5'h01, 32'h00000100, 1'b0);
    for (int i = 0; i < 7; i++)
      rd(ri[i], rv[i], ri[i] == 5'h08);
    check({24'h0, rfreq}, 32'h0a);
    check({22'h0, lf}, 32'h0);
    wr(5'h00, 32'h00030100);
    rd(5'h00, 32'h00030100, 1'b0);
    check({20'h0, rdiv}, 32'h00a);
    complete_run();
  end
endmodule : cdcb_bank_bench
